// File: hdl/super_io_watchdog_timer.sv
// Expiry counter of the super I/O controller with index/data host port
`timescale 1ns/10ps
`default_nettype none

module super_io_watchdog_timer
#(
  parameter int FAST_CYCLES = watchdog_pkg::FAST_UNIT_CYCLES,
  parameter int SEC_CYCLES = watchdog_pkg::SECOND_CYCLES,
  parameter logic POWER_GOOD_OUTPUT_DEFAULT = 1'b0
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host I/O port
  input wire watchdog_pkg::io_req_t ioReq,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  // Reload events from on-chip controllers
  input wire logic infraredReceiverIrq,
  input wire logic mouseIrq,
  input wire logic keyboardIrq,
  // Time-out outputs
  output logic keyboardResetOutputN,
  output logic powerGoodOutput,
  output logic [15:0] irqLines
);
  import watchdog_pkg::*;

  localparam wdt_cfg_t CFG_RST_VAL =
    wdt_cfg_t'(CFG_RESET | (8'(POWER_GOOD_OUTPUT_DEFAULT) << CFG_POWER_GOOD_OUTPUT_BIT));

  // Register file state
  logic [7:0] index_r;
  logic [7:0] index_nxt;
  logic [7:0] ldn_r;
  logic [7:0] ldn_nxt;
  evt_en_t evtEn_r;
  evt_en_t evtEn_nxt;
  wdt_cfg_t cfg_r;
  wdt_cfg_t cfg_nxt;
  logic [7:0] toLow_r;
  logic [7:0] toLow_nxt;
  logic [7:0] toHigh_r;
  logic [7:0] toHigh_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic rdValid_nxt;

  // Counter state
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic expired_r;
  logic expired_nxt;
  logic [2:0] evtPrev_r;
  logic [2:0] evtPrev_nxt;

  // Output sequencer state
  out_state_t outState_r;
  out_state_t outState_nxt;
  logic [7:0] pulseCnt_r;
  logic [7:0] pulseCnt_nxt;
  logic kbdN_r;
  logic kbdN_nxt;
  logic pwrGood_r;
  logic pwrGood_nxt;
  logic [15:0] irq_r;
  logic [15:0] irq_nxt;

  // Decode and events
  logic idxWr;
  logic idxRd;
  logic dataWr;
  logic dataRd;
  logic wdtSel;
  logic forceReq;
  logic wrLow;
  logic wrHigh;
  logic [2:0] evtNow;
  logic [2:0] evtRise;
  logic reloadReq;
  logic expireEvt;
  logic restartTick;
  logic unitTick;
  unit_t unitSel;
  logic [7:0] regRead;

  // Port decode; watchdog registers only map while device 7 is selected
  // index then data
  always_comb
  begin
    idxWr = ioReq.wr && (ioReq.addr == IDX_PORT_ADDR);
    idxRd = ioReq.rd && (ioReq.addr == IDX_PORT_ADDR);
    dataWr = ioReq.wr && (ioReq.addr == DATA_PORT_ADDR);
    dataRd = ioReq.rd && (ioReq.addr == DATA_PORT_ADDR);
    wdtSel = (ldn_r == LDN_WATCHDOG);
    forceReq = dataWr && wdtSel && (index_r == REG_EVT_CTL) &&
               ioReq.data[EVT_FORCE_BIT];
    wrLow = dataWr && wdtSel && (index_r == REG_TO_LOW);
    wrHigh = dataWr && wdtSel && (index_r == REG_TO_HIGH);
  end

  // Read mux; force bit never stored, so it always reads zero
  always_comb
  begin
    regRead = UNMAPPED_READ;
    if (index_r == REG_LDN)
    begin
      regRead = ldn_r;
    end
    else if (wdtSel)
    begin
      case (index_r)
        REG_EVT_CTL: regRead = {evtEn_r, EVT_RSVD_READ, cnt_r == CNT_ZERO};
        REG_CFG: regRead = cfg_r;
        REG_TO_LOW: regRead = toLow_r;
        REG_TO_HIGH: regRead = toHigh_r;
        default: regRead = UNMAPPED_READ;
      endcase
    end
  end

  // Register file next values
  always_comb
  begin
    index_nxt = index_r;
    ldn_nxt = ldn_r;
    evtEn_nxt = evtEn_r;
    cfg_nxt = cfg_r;
    toLow_nxt = toLow_r;
    toHigh_nxt = toHigh_r;
    rdData_nxt = rdData_r;
    rdValid_nxt = 1'b0;
    if (idxWr)
    begin
      index_nxt = ioReq.data;
    end
    if (dataWr)
    begin
      if (index_r == REG_LDN)
      begin
        ldn_nxt = ioReq.data;
      end
      else if (wdtSel)
      begin
        case (index_r)
          REG_EVT_CTL: evtEn_nxt = evt_en_t'(ioReq.data[EVT_IR_BIT -: 3]);
          REG_CFG: cfg_nxt = wdt_cfg_t'(ioReq.data);
          REG_TO_LOW: toLow_nxt = ioReq.data;
          REG_TO_HIGH: toHigh_nxt = ioReq.data;
          default: ;
        endcase
      end
    end
    if (idxRd)
    begin
      rdData_nxt = index_r;
      rdValid_nxt = 1'b1;
    end
    else if (dataRd)
    begin
      rdData_nxt = regRead;
      rdValid_nxt = 1'b1;
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      index_r <= IDX_RESET;
      ldn_r <= LDN_RESET;
      evtEn_r <= evt_en_t'(EVT_EN_RESET);
      cfg_r <= CFG_RST_VAL;
      toLow_r <= TO_LOW_RESET;
      toHigh_r <= TO_HIGH_RESET;
      rdData_r <= UNMAPPED_READ;
      rdValid_r <= 1'b0;
    end
    else
    begin
      index_r <= index_nxt;
      ldn_r <= ldn_nxt;
      evtEn_r <= evtEn_nxt;
      cfg_r <= cfg_nxt;
      toLow_r <= toLow_nxt;
      toHigh_r <= toHigh_nxt;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // Time base selection: fast unit overrides seconds/minutes
  // unit select
  always_comb
  begin
    if (cfg_r.fastUnit)
      unitSel = UNIT_FAST;
    else if (cfg_r.unitSec)
      unitSel = UNIT_SEC;
    else
      unitSel = UNIT_MIN;
  end

  unit_tick_gen #(
    .FAST_CYCLES(FAST_CYCLES),
    .SEC_CYCLES(SEC_CYCLES),
    .SEC_PER_MIN(SECONDS_PER_MINUTE)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(restartTick),
    .unitSel(unitSel),
    .tick(unitTick)
  );

  // Counter; reloads only re-arm a running count, never a stopped one
  always_comb
  begin
    evtNow = {infraredReceiverIrq, mouseIrq, keyboardIrq};
    evtRise = evtNow & ~evtPrev_r;
    reloadReq = (|(evtRise & evtEn_r)) && (cnt_r != CNT_ZERO);
    evtPrev_nxt = evtNow;
    cnt_nxt = cnt_r;
    expireEvt = 1'b0;
    restartTick = 1'b0;
    if (forceReq)
    begin
      cnt_nxt = CNT_ZERO;
      expireEvt = 1'b1;
    end
    else if (wrLow)
    begin
      cnt_nxt = {toHigh_r, ioReq.data};
      restartTick = 1'b1;
    end
    else if (wrHigh)
    begin
      cnt_nxt = {ioReq.data, toLow_r};
      restartTick = 1'b1;
    end
    else if (reloadReq)
    begin
      cnt_nxt = {toHigh_r, toLow_r};
      restartTick = 1'b1;
    end
    else if (unitTick && (cnt_r != CNT_ZERO))
    begin
      cnt_nxt = cnt_r - CNT_ONE;
      expireEvt = (cnt_r == CNT_ONE);
    end
    expired_nxt = expireEvt ? 1'b1 : (restartTick ? 1'b0 : expired_r);
  end

  // Counter flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r <= CNT_ZERO;
      expired_r <= 1'b0;
      evtPrev_r <= EVT_EN_RESET;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
      evtPrev_r <= evtPrev_nxt;
    end
  end

  // Output pulse sequencer; a second time-out mid-pulse is absorbed
  always_comb
  begin
    outState_nxt = outState_r;
    pulseCnt_nxt = pulseCnt_r;
    kbdN_nxt = kbdN_r;
    pwrGood_nxt = pwrGood_r;
    case (outState_r)
      OUT_IDLE:
      begin
        if (expireEvt && (cfg_r.krstEn || cfg_r.pwrgdEn))
        begin
          outState_nxt = OUT_PULSE;
          pulseCnt_nxt = PULSE_LAST;
          kbdN_nxt = !cfg_r.krstEn;
          pwrGood_nxt = !cfg_r.pwrgdEn;
        end
      end
      OUT_PULSE:
      begin
        if (pulseCnt_r == '0)
        begin
          outState_nxt = OUT_IDLE;
          kbdN_nxt = 1'b1;
          pwrGood_nxt = 1'b1;
        end
        else
        begin
          pulseCnt_nxt = pulseCnt_r - 8'h01;
        end
      end
      default:
      begin
        outState_nxt = OUT_IDLE;
        kbdN_nxt = 1'b1;
        pwrGood_nxt = 1'b1;
      end
    endcase
    irq_nxt = (expired_r && (cfg_r.irqLevel != IRQ_LEVEL_NONE)) ?
              (IRQ_BIT0 << cfg_r.irqLevel) : IRQ_NONE;
  end

  // Output flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      outState_r <= OUT_IDLE;
      pulseCnt_r <= '0;
      kbdN_r <= 1'b1;
      pwrGood_r <= 1'b1;
      irq_r <= IRQ_NONE;
    end
    else
    begin
      outState_r <= outState_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      kbdN_r <= kbdN_nxt;
      pwrGood_r <= pwrGood_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign ioRdData = rdData_r;
  assign ioRdValid = rdValid_r;
  assign keyboardResetOutputN = kbdN_r;
  assign powerGoodOutput = pwrGood_r;
  assign irqLines = irq_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_idx_low;
    idxWr && (ioReq.data == REG_TO_LOW) && wdtSel;
  endsequence

  sequence s_keyboard_reset_output_low;
    !keyboardResetOutputN [*8];
  endsequence

  property p_expire_reset;
    unitTick && (cnt_r == CNT_ONE) && !forceReq && !wrLow && !wrHigh &&
      !reloadReq |=> (cnt_r == CNT_ZERO) && expired_r;
  endproperty
  a_expire_reset: assert property (p_expire_reset)
    else $error("count did not expire at zero");

  property p_load;
    wrLow && !forceReq |=> cnt_r == {toHigh_r, $past(ioReq.data)};
  endproperty
  a_load: assert property (p_load)
    else $error("low byte write did not load the counter");

  // Index write, a quiet cycle, then the data write to the low byte
  property p_index_data;
    s_idx_low ##1 !idxWr ##1 dataWr |=> toLow_r == $past(ioReq.data);
  endproperty
  a_index_data: assert property (p_index_data)
    else $error("index/data write missed the low byte");

  property p_reload;
    reloadReq && !forceReq && !wrLow && !wrHigh |=>
      cnt_r == {toHigh_r, toLow_r} && !expired_r;
  endproperty
  a_reload: assert property (p_reload)
    else $error("enabled event did not reload the counter");

  property p_force;
    forceReq |=> (cnt_r == CNT_ZERO) && expired_r;
  endproperty
  a_force: assert property (p_force)
    else $error("forced time-out did not take effect");

  property p_status;
    dataRd && wdtSel && (index_r == REG_EVT_CTL) |=>
      ioRdValid && (ioRdData[0] == $past(cnt_r == CNT_ZERO)) &&
      !ioRdData[EVT_FORCE_BIT];
  endproperty
  a_status: assert property (p_status)
    else $error("status bit does not track a zero count");

  property p_keyboard_reset_output;
    expireEvt && cfg_r.krstEn && (outState_r == OUT_IDLE) |=> s_keyboard_reset_output_low;
  endproperty
  a_keyboard_reset_output: assert property (p_keyboard_reset_output)
    else $error("keyboard reset pulse missing or too short");

  property p_keyboard_reset_output_off;
    expireEvt && !cfg_r.krstEn && (outState_r == OUT_IDLE) |=>
      keyboardResetOutputN;
  endproperty
  a_keyboard_reset_output_off: assert property (p_keyboard_reset_output_off)
    else $error("keyboard reset driven while disabled");

  property p_power_good_output;
    expireEvt && (outState_r == OUT_IDLE) |=>
      (powerGoodOutput == !$past(cfg_r.pwrgdEn)) [*4];
  endproperty
  a_power_good_output: assert property (p_power_good_output)
    else $error("power-good reaction does not follow its enable");

  property p_irq;
    expireEvt && (cfg_r.irqLevel != IRQ_LEVEL_NONE) ##1
      (expired_r && $stable(cfg_r)) |=> irqLines[cfg_r.irqLevel];
  endproperty
  a_irq: assert property (p_irq)
    else $error("selected interrupt level not raised");

  property p_preset_reset;
    $fell(rst) |-> (toLow_r == TO_LOW_RESET) && (toHigh_r == TO_HIGH_RESET);
  endproperty
  a_preset_reset: assert property (p_preset_reset)
    else $error("preset bytes wrong after reset");

  property p_step;
    unitTick && (cnt_r > CNT_ONE) && !forceReq && !wrLow && !wrHigh &&
      !reloadReq |=> (cnt_r == $past(cnt_r) - CNT_ONE) && !expired_r [*1];
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one unit");

endmodule

`default_nettype wire

// File: hdl/watchdog_pkg.sv
// Shared types and constants for the super I/O expiry counter block
package watchdog_pkg;

  // Time base of the counter
  typedef enum logic [1:0] {
    UNIT_FAST = 2'b00,
    UNIT_SEC  = 2'b01,
    UNIT_MIN  = 2'b10
  } unit_t;

  // Time-out pulse sequencer
  typedef enum logic {
    OUT_IDLE  = 1'b0,
    OUT_PULSE = 1'b1
  } out_state_t;

  // One host I/O cycle, same clock as the block
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } io_req_t;

  // Configuration register layout, bit 7 down to bit 0
  typedef struct packed {
    logic unitSec;
    logic krstEn;
    logic fastUnit;
    logic pwrgdEn;
    logic [3:0] irqLevel;
  } wdt_cfg_t;

  // Reload enables held in event-control bits 7..5
  typedef struct packed {
    logic irEn;
    logic mouseEn;
    logic kbdEn;
  } evt_en_t;

  // Host I/O ports
  localparam logic [15:0] IDX_PORT_ADDR = 16'h002e;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h002f;

  // Configuration index space
  localparam logic [7:0] REG_LDN = 8'h07;
  localparam logic [7:0] LDN_WATCHDOG = 8'h07;
  localparam logic [7:0] REG_EVT_CTL = 8'h71;
  localparam logic [7:0] REG_CFG = 8'h72;
  localparam logic [7:0] REG_TO_LOW = 8'h73;
  localparam logic [7:0] REG_TO_HIGH = 8'h74;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Reset values
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [7:0] LDN_RESET = 8'h00;
  localparam logic [2:0] EVT_EN_RESET = 3'h0;
  localparam logic [7:0] CFG_RESET = 8'h20;
  localparam logic [7:0] TO_LOW_RESET = 8'h38;
  localparam logic [7:0] TO_HIGH_RESET = 8'h00;

  // Field positions
  localparam int EVT_IR_BIT = 7;
  localparam int EVT_FORCE_BIT = 1;
  localparam int CFG_POWER_GOOD_OUTPUT_BIT = 4;
  localparam logic [3:0] EVT_RSVD_READ = 4'h0;

  // Counter and interrupt constants
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] IRQ_LEVEL_NONE = 4'h0;
  localparam logic [15:0] IRQ_NONE = 16'h0000;
  localparam logic [15:0] IRQ_BIT0 = 16'h0001;

  // Timing, in nanoseconds and derived clock cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int FAST_UNIT_NS = 62_500_000;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int PULSE_NS = 500;
  localparam int FAST_UNIT_CYCLES = FAST_UNIT_NS / CLK_PERIOD_NS;
  localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYCLES - 1);

endpackage

// File: hdl/unit_tick_gen.sv
// Time base divider: one tick per fast unit, second or minute
`timescale 1ns/10ps
`default_nettype none

module unit_tick_gen
#(
  parameter int FAST_CYCLES = watchdog_pkg::FAST_UNIT_CYCLES,
  parameter int SEC_CYCLES = watchdog_pkg::SECOND_CYCLES,
  parameter int SEC_PER_MIN = watchdog_pkg::SECONDS_PER_MINUTE
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire watchdog_pkg::unit_t unitSel,
  // Tick out
  output logic tick
);
  import watchdog_pkg::*;

  logic [31:0] cycCnt_r;
  logic [31:0] cycCnt_nxt;
  logic [7:0] secCnt_r;
  logic [7:0] secCnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [31:0] limit;
  logic cycWrap;

  // Divider next state; >= so a unit change never overruns the limit
  always_comb
  begin
    limit = (unitSel == UNIT_FAST) ? 32'(FAST_CYCLES - 1)
                                   : 32'(SEC_CYCLES - 1);
    cycWrap = (cycCnt_r >= limit);
    cycCnt_nxt = cycWrap ? '0 : cycCnt_r + 32'h1;
    secCnt_nxt = secCnt_r;
    tick_nxt = 1'b0;
    if (restart)
    begin
      cycCnt_nxt = '0;
      secCnt_nxt = '0;
    end
    else if (cycWrap)
    begin
      case (unitSel)
        UNIT_MIN:
        begin
          if (secCnt_r >= 8'(SEC_PER_MIN - 1))
          begin
            secCnt_nxt = '0;
            tick_nxt = 1'b1;
          end
          else
          begin
            secCnt_nxt = secCnt_r + 8'h01;
          end
        end
        default:
        begin
          secCnt_nxt = '0;
          tick_nxt = 1'b1;
        end
      endcase
    end
  end

  // Divider registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cycCnt_r <= '0;
      secCnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cycCnt_r <= cycCnt_nxt;
      secCnt_r <= secCnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the super I/O expiry counter block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import watchdog_pkg::*;

  // Shortened time base so a minute is 2400 cycles
  localparam int FAST = 20;
  localparam int SEC = 40;

  // Stimulus and observed signals
  logic clk_sys;
  logic rst;
  io_req_t ioReq;
  logic [7:0] ioRdData;
  logic ioRdValid;
  logic [2:0] evt;
  logic keyboardResetOutputN;
  logic powerGoodOutput;
  logic [15:0] irqLines;
  int miscompares;
  int n_checks;
  int krstLowCnt;
  int pgLowCnt;
  int irqHiCnt;
  logic [7:0] rdVal;
  logic rdOk;

  super_io_watchdog_timer #(
    .FAST_CYCLES(FAST),
    .SEC_CYCLES(SEC),
    .POWER_GOOD_OUTPUT_DEFAULT(1'b0)
  ) DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .ioReq(ioReq),
    .ioRdData(ioRdData),
    .ioRdValid(ioRdValid),
    .infraredReceiverIrq(evt[2]),
    .mouseIrq(evt[1]),
    .keyboardIrq(evt[0]),
    .keyboardResetOutputN(keyboardResetOutputN),
    .powerGoodOutput(powerGoodOutput),
    .irqLines(irqLines)
  );

  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Cycle counters for the time-out outputs
  always @(posedge clk_sys)
  begin
    if (keyboardResetOutputN === 1'b0)
      krstLowCnt++;
    if (powerGoodOutput === 1'b0)
      pgLowCnt++;
    if (irqLines !== 16'h0000)
      irqHiCnt++;
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // One host cycle; the answer is sampled once it has settled
  task automatic io_cyc(input logic wr, input logic [15:0] addr,
                        input logic [7:0] data);
    @(posedge clk_sys);
    ioReq <= '{wr: wr, rd: ~wr, addr: addr, data: data};
    @(posedge clk_sys);
    ioReq <= '{wr: 1'b0, rd: 1'b0, addr: addr, data: data};
    #1;
    rdOk = ioRdValid;
    rdVal = ioRdData;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    io_cyc(1'b1, IDX_PORT_ADDR, idx);
    io_cyc(1'b1, DATA_PORT_ADDR, d);
  endtask

  // Read through the data port and compare valid flag plus data
  task automatic chk_reg(input string nm, input logic [7:0] idx,
                         input logic [7:0] exp);
    io_cyc(1'b1, IDX_PORT_ADDR, idx);
    io_cyc(1'b0, DATA_PORT_ADDR, 8'h00);
    chk(nm, {8'h01, exp}, {7'h00, rdOk, rdVal});
  endtask

  // Irq must fall after a load, then count cycles until it rises
  task automatic wait_irq(input int limit, output int n);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq cleared by load", 16'h0000, irqLines);
    n = 2;
    while (irqLines === 16'h0000 && n < limit)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  // One-cycle pulse on the selected event inputs
  task automatic pulse_evt(input logic [2:0] m);
    @(posedge clk_sys);
    evt <= m;
    @(posedge clk_sys);
    evt <= 3'h0;
  endtask

  task automatic t_reset();
    chk("irq idle", 16'h0000, irqLines);
    chk("pulse outputs idle", 16'h0003,
        {14'h0, keyboardResetOutputN, powerGoodOutput});
    chk_reg("low without device", REG_TO_LOW, 8'h00);
    reg_wr(REG_LDN, LDN_WATCHDOG);
    io_cyc(1'b0, IDX_PORT_ADDR, 8'h00);
    chk("index readback", 16'h0107, {7'h00, rdOk, rdVal});
    chk_reg("event ctl reset", REG_EVT_CTL, 8'h01);
    chk_reg("config reset", REG_CFG, 8'h20);
    chk_reg("low reset", REG_TO_LOW, 8'h38);
    chk_reg("high reset", REG_TO_HIGH, 8'h00);
    chk_reg("unmapped index", 8'h30, 8'h00);
    io_cyc(1'b0, 16'h0080, 8'h00);
    chk("stray address answer", 16'h0000, {15'h0, rdOk});
    $display("t_reset done");
  endtask

  task automatic t_countdown();
    int n;
    reg_wr(REG_CFG, 8'h25);
    reg_wr(REG_TO_HIGH, 8'h00);
    krstLowCnt = 0;
    pgLowCnt = 0;
    reg_wr(REG_TO_LOW, 8'h03);
    wait_irq(200, n);
    chk_rng("three fast units", 3 * FAST - 2, 3 * FAST + 12, n);
    chk("irq level five", 16'h0020, irqLines);
    chk_reg("status at zero", REG_EVT_CTL, 8'h01);
    repeat (24) @(posedge clk_sys);
    // Look after the edge so the counters have settled
    #1;
    chk("keyboard_reset_output held off", 16'h0000, 16'(krstLowCnt));
    chk("pg held off", 16'h0000, 16'(pgLowCnt));
    chk("irq held at zero", 16'h0020, irqLines);
    $display("t_countdown done");
  endtask

  // Unit length for one config value, with a count of one
  task automatic time_unit(input logic [7:0] cfg, input int u,
                           input string nm);
    int n;
    reg_wr(REG_CFG, cfg);
    reg_wr(REG_TO_LOW, 8'h01);
    wait_irq(u + u / 10 + 50, n);
    chk_rng(nm, u - 2, u + u / 20 + 8, n);
  endtask

  task automatic t_units();
    time_unit(8'ha1, FAST, "fast over seconds");
    time_unit(8'h81, SEC, "second unit");
    time_unit(8'h01, 60 * SEC, "minute unit");
    time_unit(8'h21, FAST, "fast over minutes");
    $display("t_units done");
  endtask

  task automatic t_force();
    reg_wr(REG_CFG, 8'h53);
    reg_wr(REG_TO_HIGH, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk("counting, no irq", 16'h0000, irqLines);
    // A running count must read its zero flag low
    chk_reg("status counting", REG_EVT_CTL, 8'h00);
    krstLowCnt = 0;
    pgLowCnt = 0;
    reg_wr(REG_EVT_CTL, 8'h02);
    repeat (30) @(posedge clk_sys);
    #1;
    chk("keyboard_reset_output pulse", 16'(PULSE_CYCLES), 16'(krstLowCnt));
    chk("pg pulse", 16'(PULSE_CYCLES), 16'(pgLowCnt));
    chk("irq level three", 16'h0008, irqLines);
    io_cyc(1'b0, DATA_PORT_ADDR, 8'h00);
    chk("force bit clear", 16'h0100, {7'h0, rdOk, rdVal & 8'hfe});
    $display("t_force done");
  endtask

  // Each enable reloads from its own input only
  task automatic t_reload();
    logic [2:0] m;
    reg_wr(REG_CFG, 8'h25);
    // High byte left at 01h by the force test; clear it so the preset is 2
    reg_wr(REG_TO_HIGH, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      m = 3'b100 >> k;
      reg_wr(REG_EVT_CTL, {m, 5'h00});
      reg_wr(REG_TO_LOW, 8'h02);
      repeat (2) @(posedge clk_sys);
      irqHiCnt = 0;
      for (int r = 0; r < 3; r++)
      begin
        repeat (25) @(posedge clk_sys);
        pulse_evt(m);
      end
      chk("reloaded, no expiry", 16'h0000, 16'(irqHiCnt));
      chk_reg("enables readback", REG_EVT_CTL, {m, 5'h00});
      for (int r = 0; r < 6; r++)
      begin
        repeat (12) @(posedge clk_sys);
        pulse_evt(~m);
      end
      #1;
      chk("others ignored", 16'h0020, irqLines);
    end
    $display("t_reload done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well past the expected run of about 3300 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    ioReq = '0;
    evt = 3'h0;
    miscompares = 0;
    n_checks = 0;
    krstLowCnt = 0;
    pgLowCnt = 0;
    irqHiCnt = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_countdown();
    t_units();
    t_force();
    t_reload();
    test_done();
  end

endmodule

`default_nettype wire
